// file: common/timer16_map.svh
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH

// Register byte offsets on the APB window
`define OFS_CTRL     8'h00
`define OFS_IRQ_EN   8'h04
`define OFS_FLAGS    8'h08
`define OFS_FORCE    8'h0C
`define OFS_CNT_LO   8'h10
`define OFS_CNT_HI   8'h14
`define OFS_CMPA_LO  8'h18
`define OFS_CMPA_HI  8'h1C
`define OFS_CMPB_LO  8'h20
`define OFS_CMPB_HI  8'h24
`define OFS_TOP_VAL  8'h28
`define OFS_OUT_STAT 8'h2C

// Control register fields
`define CTRL_MODE    3:0
`define CTRL_ACT_A   5:4
`define CTRL_ACT_B   7:6
`define CTRL_RUN     8
`define BYTE_LO      7:0
`define BYTE_HI      15:8
`define HALF_LO      15:0

// Reset values
`define RST_MODE     4'h0
`define RST_ACT      2'h0
`define RST_WORD     16'h0000
`define RST_BYTE     8'h00

// Count extremes and fixed tops
`define CNT_BOTTOM   16'h0000
`define CNT_MAX      16'hFFFF
`define CNT_ONE      16'h0001
`define TOP_8BIT     16'h00FF
`define TOP_9BIT     16'h01FF
`define TOP_10BIT    16'h03FF

// Per-mode masks, bit n set when mode n has the property
`define MASK_FAST    16'hC0E0
`define MASK_PHASE   16'h0F0E
`define MASK_TOP_A   16'h8A10
`define MASK_TOP_CAP 16'h5500
`define MASK_TOP8    16'h0022
`define MASK_TOP9    16'h0044
`define MASK_TOP10   16'h0088
`define MASK_UPD_BOT 16'h0300
`define MASK_TGL_A   16'h8A00

// Compare output actions
`define ACT_NONE     2'h0
`define ACT_TOGGLE   2'h1
`define ACT_CLEAR    2'h2
`define ACT_SET      2'h3

`endif

// file: common/timer16_pkg.sv
package timer16_pkg;

   // Class of counting sequence selected by the mode
   typedef enum logic [1:0] {
      KIND_NORMAL,
      KIND_FAST,
      KIND_PHASE
   } wave_kind_e;

   // Whole state of the top module
   typedef struct packed {
      logic [3:0]  mode;
      logic [1:0]  act_a;
      logic [1:0]  act_b;
      logic        run;
      logic [1:0]  irq_en;
      logic [15:0] count;
      logic [7:0]  temp;
      logic [7:0]  snap_hi;
      logic [15:0] top_val;
      logic        block;
      logic        down;
      logic [31:0] prdata;
   } main_state_s;

   // Whole state of one compare channel
   typedef struct packed {
      logic [15:0] active;
      logic [15:0] buffer;
      logic        flag;
      logic        latch;
   } chan_state_s;

   // Whole state of the tick divider
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } div_state_s;

endpackage : timer16_pkg

// file: core/tick_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer16_map.svh"

module tick_divider #(
   parameter logic [15:0] DIV = 16'h0001
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic enable,
   output logic      tick
);

   timer16_pkg::div_state_s st_reg;  // Current state
   timer16_pkg::div_state_s st_next; // Next state

   // One-cycle pulse every DIV cycles while enabled
   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (!enable) begin
         // Stopped: restart the phase
         st_next.cnt = `RST_WORD;
      end else if (st_reg.cnt >= DIV - `CNT_ONE) begin
         st_next.cnt = `RST_WORD;
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + `CNT_ONE;
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick = st_reg.tick;

endmodule : tick_divider
`default_nettype wire

// file: core/compare_channel.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer16_map.svh"

module compare_channel (
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   input  wire logic [15:0]             count,
   input  wire logic                    tick,
   input  wire logic                    block,
   input  wire timer16_pkg::wave_kind_e kind,
   input  wire logic                    db_on,
   input  wire logic                    load_now,
   input  wire logic                    wrap,
   input  wire logic                    down,
   input  wire logic [1:0]              act,
   input  wire logic                    toggle_ok,
   input  wire logic                    force_strobe,
   input  wire logic                    wr_en,
   input  wire logic [15:0]             wr_value,
   input  wire logic                    flag_clr,
   input  wire logic                    irq_ack,
   input  wire logic                    irq_en,
   output logic [15:0]                  cpu_view,
   output logic [15:0]                  active,
   output logic                         match,
   output logic                         flag,
   output logic                         irq,
   output logic                         latch
);

   timer16_pkg::chan_state_s st_reg;  // Current state
   timer16_pkg::chan_state_s st_next; // Next state
   logic                     hit;     // Match taken at a timer tick
   logic [1:0]               pwm_act; // Action with illegal toggle removed

   // Apply an action to the latch
   function automatic logic apply(input logic [1:0] a, input logic cur);
      case (a)
         `ACT_TOGGLE: apply = ~cur;
         `ACT_CLEAR:  apply = 1'b0;
         `ACT_SET:    apply = 1'b1;
         default:     apply = cur;
      endcase
   endfunction : apply

   // Swap set and clear for the opposite slope
   function automatic logic [1:0] flip(input logic [1:0] a);
      case (a)
         `ACT_CLEAR: flip = `ACT_SET;
         `ACT_SET:   flip = `ACT_CLEAR;
         default:    flip = a;
      endcase
   endfunction : flip

   // Equality checked every cycle
   assign match = (count == st_reg.active);
   // Match acts one tick later unless a count write blocks it
   assign hit = tick & match & ~block;
   assign pwm_act = (act == `ACT_TOGGLE && !toggle_ok) ? `ACT_NONE : act;

   // Next-state logic
   always_comb begin
      st_next = st_reg;
      // Buffer moves to compare only at top or bottom
      if (load_now) begin
         st_next.active = st_reg.buffer;
      end
      // Value changes only by writes; target depends on buffering
      if (wr_en) begin
         st_next.buffer = wr_value;
         if (!db_on) begin
            st_next.active = wr_value;
         end
      end
      // Clear by service or write-one, set wins
      if (flag_clr || irq_ack) begin
         st_next.flag = 1'b0;
      end
      if (hit) begin
         st_next.flag = 1'b1;
      end
      // Latch update; action is read live, mode change keeps latch
      case (kind)
         timer16_pkg::KIND_NORMAL: begin
            // Forced match acts like a real one, no flag
            if (hit || force_strobe) begin
               st_next.latch = apply(act, st_reg.latch);
            end
         end
         timer16_pkg::KIND_FAST: begin
            // Wrap to bottom starts a new pulse
            if (wrap) begin
               st_next.latch = apply(flip(pwm_act), st_reg.latch);
            end
            if (hit) begin
               st_next.latch = apply(pwm_act, st_reg.latch);
            end
         end
         timer16_pkg::KIND_PHASE: begin
            // Opposite action on the down slope
            if (hit) begin
               st_next.latch = apply(down ? flip(pwm_act) : pwm_act,
                                     st_reg.latch);
            end
         end
         default: begin
            st_next.latch = st_reg.latch;
         end
      endcase
   end

   // State register, latch reset low
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cpu_view = db_on ? st_reg.buffer : st_reg.active;
   assign active   = st_reg.active;
   assign flag     = st_reg.flag;
   assign irq      = st_reg.flag & irq_en;
   assign latch    = st_reg.latch;

endmodule : compare_channel
`default_nettype wire

// file: core/timer16_output_compare.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer16_map.svh"

// Function
// - Compare count with each compare value always
// - Flag sets one timer tick after equality
// - Enabled flag requests interrupt; service or one clears
// - Waveform acts on match, mode, top, bottom
// - Channel A value can set counter top
// - Double buffering in PWM modes only
// - Buffered value loads at top or bottom
// - CPU reaches buffer or compare register directly
// - Value changes only by writes; direct high read
// - High byte to shadow, low write commits both
// - Force strobe updates latch in non-PWM modes
// - Action setting decides forced set, clear, toggle
// - Counter write blocks matches next timer tick
// - Written count equal to compare loses match
// - Count written to top counts on to max
// - Latch keeps value across mode changes
// - Action setting takes effect immediately
// - Reset clears output latches
// - Action zero leaves latch unchanged

module timer16_output_compare #(
   parameter logic [15:0] TICK_DIV = 16'h0001
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  irq_ack,
   output logic [1:0]       compare_irq,
   output logic [1:0]       compare_match,
   output logic [1:0]       compare_output_latch,
   output logic [1:0]       compare_pin_override,
   output logic [15:0]      timer_count
);

   // Mode property tables, indexed by mode number
   localparam logic [15:0] FAST_MASK  = `MASK_FAST;
   localparam logic [15:0] PHASE_MASK = `MASK_PHASE;
   localparam logic [15:0] TOPA_MASK  = `MASK_TOP_A;
   localparam logic [15:0] TOPC_MASK  = `MASK_TOP_CAP;
   localparam logic [15:0] TOP8_MASK  = `MASK_TOP8;
   localparam logic [15:0] TOP9_MASK  = `MASK_TOP9;
   localparam logic [15:0] TOP10_MASK = `MASK_TOP10;
   localparam logic [15:0] UPDB_MASK  = `MASK_UPD_BOT;
   localparam logic [15:0] TGLA_MASK  = `MASK_TGL_A;

   timer16_pkg::main_state_s st_reg;    // Current state
   timer16_pkg::main_state_s st_next;   // Next state
   timer16_pkg::wave_kind_e  kind;      // Counting class
   logic [15:0]              top;       // Current top value
   logic                     db_on;     // Double buffering active
   logic                     upd_bot;   // Buffer loads at bottom
   logic                     tgl_a;     // Toggle allowed on channel A
   logic                     tick;      // Timer clock enable
   logic                     at_top;    // Count equals top
   logic                     at_bottom; // Count is zero
   logic                     top_hit;   // Unblocked top reached at tick
   logic                     load_now;  // Buffer transfer strobe
   logic                     wrap;      // Fast PWM wrap to bottom
   logic                     setup;     // APB setup cycle
   logic                     wr_acc;    // APB write access
   logic                     rd_acc;    // APB read access
   logic                     mapped;    // Address hits a register
   logic [31:0]              rd_mux;    // Read data for the address
   logic [1:0]               chan_wr;   // Low-byte compare commits
   logic [1:0]               force_stb; // Force strobes
   logic [1:0]               flag_clr;  // Write-one flag clears
   logic [1:0]               flag;      // Match flags
   logic [1:0][1:0]          act;       // Per-channel actions
   logic [1:0][15:0]         cpu_view;  // CPU view of compare values
   logic [1:0][15:0]         active;    // Values in the comparators
   logic [1:0][7:0]          lo_ofs;    // Low-byte offsets per channel

   // APB phase decode
   assign setup  = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;

   // Zero wait state slave, error on unmapped address
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = st_reg.prdata;

   // Timer clock enable, counting gated by run bit
   tick_divider #(
      .DIV (TICK_DIV)
   ) u_div (
      .clock  (clock),
      .rst_n  (rst_n),
      .enable (st_reg.run),
      .tick   (tick)
   );

   // Mode decode: counting class, top and buffering
   always_comb begin
      kind = timer16_pkg::KIND_NORMAL;
      if (FAST_MASK[st_reg.mode]) begin
         kind = timer16_pkg::KIND_FAST;
      end else if (PHASE_MASK[st_reg.mode]) begin
         kind = timer16_pkg::KIND_PHASE;
      end
      top = `CNT_MAX;
      if (TOPA_MASK[st_reg.mode]) begin
         // Channel A sets resolution and period
         top = active[0];
      end else if (TOPC_MASK[st_reg.mode]) begin
         top = st_reg.top_val;
      end else if (TOP8_MASK[st_reg.mode]) begin
         top = `TOP_8BIT;
      end else if (TOP9_MASK[st_reg.mode]) begin
         top = `TOP_9BIT;
      end else if (TOP10_MASK[st_reg.mode]) begin
         top = `TOP_10BIT;
      end
      // All PWM classes buffer, normal and clear-on-match do not
      db_on   = (kind != timer16_pkg::KIND_NORMAL);
      upd_bot = UPDB_MASK[st_reg.mode];
      tgl_a   = TGLA_MASK[st_reg.mode];
   end

   // Extremes; a blocked top is ignored so counting runs on
   assign at_top    = (st_reg.count == top);
   assign at_bottom = (st_reg.count == `CNT_BOTTOM);
   assign top_hit   = tick & at_top & ~st_reg.block;
   assign wrap      = (kind == timer16_pkg::KIND_FAST) & top_hit;

   // Buffer transfer point: top, or bottom in some dual-slope modes
   always_comb begin
      load_now = 1'b0;
      if (db_on) begin
         if (upd_bot) begin
            load_now = tick & st_reg.down & at_bottom;
         end else if (kind == timer16_pkg::KIND_FAST) begin
            load_now = top_hit;
         end else begin
            load_now = top_hit & ~st_reg.down;
         end
      end
   end

   // Address decode and read data selection
   always_comb begin
      rd_mux = '0;
      mapped = 1'b1;
      case (paddr)
         `OFS_CTRL: begin
            rd_mux[`CTRL_MODE]  = st_reg.mode;
            rd_mux[`CTRL_ACT_A] = st_reg.act_a;
            rd_mux[`CTRL_ACT_B] = st_reg.act_b;
            rd_mux[`CTRL_RUN]   = st_reg.run;
         end
         `OFS_IRQ_EN: begin
            rd_mux[1:0] = st_reg.irq_en;
         end
         `OFS_FLAGS: begin
            rd_mux[1:0] = flag;
         end
         `OFS_FORCE: begin
            // Strobes read as zero
            rd_mux = '0;
         end
         `OFS_CNT_LO: begin
            rd_mux[`BYTE_LO] = st_reg.count[`BYTE_LO];
         end
         `OFS_CNT_HI: begin
            // High count byte comes through the shadow
            rd_mux[`BYTE_LO] = st_reg.temp;
         end
         `OFS_CMPA_LO: begin
            rd_mux[`BYTE_LO] = cpu_view[0][`BYTE_LO];
         end
         `OFS_CMPA_HI: begin
            // Stored byte, not the shadow
            rd_mux[`BYTE_LO] = cpu_view[0][`BYTE_HI];
         end
         `OFS_CMPB_LO: begin
            rd_mux[`BYTE_LO] = cpu_view[1][`BYTE_LO];
         end
         `OFS_CMPB_HI: begin
            rd_mux[`BYTE_LO] = cpu_view[1][`BYTE_HI];
         end
         `OFS_TOP_VAL: begin
            rd_mux[`HALF_LO] = st_reg.top_val;
         end
         `OFS_OUT_STAT: begin
            rd_mux[1:0] = compare_output_latch;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // Next state: read capture, counting, register writes
   always_comb begin
      st_next = st_reg;
      // Read data is taken in setup, valid in access
      if (setup) begin
         st_next.prdata = rd_mux;
         if (paddr == `OFS_CNT_LO) begin
            st_next.snap_hi = st_reg.count[`BYTE_HI];
         end
      end
      // Counting at each timer tick
      if (tick) begin
         // One tick of blocking is used up
         st_next.block = 1'b0;
         if (kind == timer16_pkg::KIND_PHASE) begin
            if (!st_reg.down) begin
               if (top_hit) begin
                  st_next.down  = 1'b1;
                  st_next.count = st_reg.count - `CNT_ONE;
               end else begin
                  st_next.count = st_reg.count + `CNT_ONE;
               end
            end else if (at_bottom) begin
               st_next.down  = 1'b0;
               st_next.count = st_reg.count + `CNT_ONE;
            end else begin
               st_next.count = st_reg.count - `CNT_ONE;
            end
         end else if (top_hit) begin
            st_next.count = `CNT_BOTTOM;
         end else begin
            // Blocked top runs on to max and wraps
            st_next.count = st_reg.count + `CNT_ONE;
         end
      end
      // Single-slope classes always count up
      if (kind != timer16_pkg::KIND_PHASE) begin
         st_next.down = 1'b0;
      end
      // Low count read moves the high byte to the shadow
      if (rd_acc && paddr == `OFS_CNT_LO) begin
         st_next.temp = st_reg.snap_hi;
      end
      // CPU writes have priority over counting
      if (wr_acc) begin
         case (paddr)
            `OFS_CTRL: begin
               // Actions act at once, never buffered
               st_next.mode  = pwdata[`CTRL_MODE];
               st_next.act_a = pwdata[`CTRL_ACT_A];
               st_next.act_b = pwdata[`CTRL_ACT_B];
               st_next.run   = pwdata[`CTRL_RUN];
            end
            `OFS_IRQ_EN: begin
               st_next.irq_en = pwdata[1:0];
            end
            `OFS_CNT_HI, `OFS_CMPA_HI, `OFS_CMPB_HI: begin
               // High byte waits in the shadow
               st_next.temp = pwdata[`BYTE_LO];
            end
            `OFS_CNT_LO: begin
               // Count write blocks the next tick's matches
               st_next.count = {st_reg.temp, pwdata[`BYTE_LO]};
               st_next.block = 1'b1;
            end
            `OFS_TOP_VAL: begin
               st_next.top_val = pwdata[`HALF_LO];
            end
            default: begin
               st_next.temp = st_next.temp;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign act[0]    = st_reg.act_a;
   assign act[1]    = st_reg.act_b;
   assign lo_ofs[0] = `OFS_CMPA_LO;
   assign lo_ofs[1] = `OFS_CMPB_LO;

   // Two independent compare channels; only channel A may toggle in PWM modes
   for (genvar i = 0; i < 2; i++) begin : g_chan
      // Low-byte write commits shadow and low byte together
      assign chan_wr[i]   = wr_acc & (paddr == lo_ofs[i]);
      // Force only in the non-PWM class
      assign force_stb[i] = wr_acc & (paddr == `OFS_FORCE) & pwdata[i]
                            & (kind == timer16_pkg::KIND_NORMAL);
      assign flag_clr[i]  = wr_acc & (paddr == `OFS_FLAGS) & pwdata[i];
      // Pin follows the latch whenever an action is chosen
      assign compare_pin_override[i] = (act[i] != `ACT_NONE);

      compare_channel u_chan (
         .clock        (clock),
         .rst_n        (rst_n),
         .count        (st_reg.count),
         .tick         (tick),
         .block        (st_reg.block),
         .kind         (kind),
         .db_on        (db_on),
         .load_now     (load_now),
         .wrap         (wrap),
         .down         (st_reg.down),
         .act          (act[i]),
         .toggle_ok    ((i == 0) ? tgl_a : 1'b0),
         .force_strobe (force_stb[i]),
         .wr_en        (chan_wr[i]),
         .wr_value     ({st_reg.temp, pwdata[`BYTE_LO]}),
         .flag_clr     (flag_clr[i]),
         .irq_ack      (irq_ack[i]),
         .irq_en       (st_reg.irq_en[i]),
         .cpu_view     (cpu_view[i]),
         .active       (active[i]),
         .match        (compare_match[i]),
         .flag         (flag[i]),
         .irq          (compare_irq[i]),
         .latch        (compare_output_latch[i])
      );
   end

   assign timer_count = st_reg.count;

endmodule : timer16_output_compare
`default_nettype wire

// file: bench/timer16_output_compare_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer16_map.svh"
// Watches the compare block from its pins only
module timer16_output_compare_checker #(
   parameter logic [15:0] TICK_DIV = 16'h0001
) (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [1:0]  irq_ack,
   input wire logic [1:0]  compare_irq,
   input wire logic [1:0]  compare_match,
   input wire logic [1:0]  compare_output_latch,
   input wire logic [1:0]  compare_pin_override,
   input wire logic [15:0] timer_count
);
   logic wr; // Write access edge
   assign wr = psel && penable && pwrite;
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_match_cause: assert property (
      $rose(compare_match[0]) |-> $changed(timer_count) || $past(wr)) else $error("match");
   a_flag_after: assert property (
      $rose(compare_irq[0]) |-> $past(compare_match[0]) || $past(wr)) else $error("flag a");
   a_irq_b_cause: assert property (
      $rose(compare_irq[1]) |-> $past(compare_match[1]) || $past(wr)) else $error("flag b");
   a_irq_clear: assert property (
      $fell(compare_irq[0]) |-> $past(irq_ack[0]) || $past(wr)) else $error("clear");
   a_cnt_block: assert property (
      wr && paddr == `OFS_CNT_LO |-> ##2 !$rose(compare_irq[0]) && !$rose(compare_irq[1]))
      else $error("block");
   a_reset_latch: assert property (
      !$past(rst_n) |-> compare_output_latch == 2'h0) else $error("reset latch");
   a_hold_a: assert property (
      !compare_pin_override[0] |=> $stable(compare_output_latch[0])) else $error("hold a");
   a_hold_b: assert property (
      !compare_pin_override[1] |=> $stable(compare_output_latch[1])) else $error("hold b");
   // Main scenarios reached
   cover property (psel && penable && pslverr);
   cover property ($rose(compare_irq[0]));
   cover property ($changed(compare_output_latch));
endmodule : timer16_output_compare_checker
bind timer16_output_compare timer16_output_compare_checker #(.TICK_DIV(TICK_DIV)) chk_inst (
   .clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .irq_ack, .compare_irq, .compare_match, .compare_output_latch, .compare_pin_override,
   .timer_count);
`default_nettype wire

// file: bench/cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// Bus master standing in for the processor
module cpu_model (
   input  wire logic        clock,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // Setup, access until pready, then release
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      @(posedge clock);
      while (pready !== 1'h1) @(posedge clock);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
   // Sixteen-bit write, high byte first into the shadow
   task automatic w16(input logic [7:0] lo, input logic [15:0] v);
      logic [31:0] q;
      logic        e;
      xfer(1'h1, lo + 8'h04, {24'h0, v[15:8]}, q, e);
      xfer(1'h1, lo, {24'h0, v[7:0]}, q, e);
   endtask : w16
endmodule : cpu_model
`default_nettype wire

// file: bench/timer16_output_compare_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer16_map.svh"
module timer16_output_compare_tb;
   logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, e, ea, eb;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [1:0]  irq_ack, compare_irq, compare_match, compare_output_latch, compare_pin_override;
   logic [15:0] timer_count;
   int          fails, samples_checked, i;
   timer16_output_compare timer16_output_compare_inst (.clock, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_ack, .compare_irq, .compare_match,
      .compare_output_latch, .compare_pin_override, .timer_count);
   cpu_model cpu_model_inst (.clock, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
      .paddr, .pwdata);
   initial begin
      clock = 1'h0;
      forever #2 clock = ~clock;
   end
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cpu_model_inst.xfer(1'h1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      cpu_model_inst.xfer(1'h0, a, 32'h0, q, e);
      chk("register", x, q);
   endtask : rd
   // Bounded wait for a count value
   task automatic wc(input logic [15:0] v);
      for (int k = 0; k < 200 && timer_count !== v; k++) @(posedge clock);
      chk("wait", {16'h0, v}, {16'h0, timer_count});
   endtask : wc
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #40000;
      fails++;
      wrap_up();
   end
   initial begin
      rst_n = 1'h0;
      irq_ack = 2'h0;
      fails = 0;
      samples_checked = 0;
      ea = 1'h0;
      eb = 1'h0;
      repeat (20) @(posedge clock);
      rst_n <= 1'h1;
      rd(`OFS_OUT_STAT, 32'h0);
      rd(8'h30, 32'h0);
      chk("error", 32'h1, {31'h0, e});
      // Every action code forced on A while B toggles
      for (i = 0; i < 4; i++) begin
         wr(`OFS_CTRL, {24'h0, 2'h1, i[1:0], 4'h0});
         wr(`OFS_FORCE, 32'h3);
         ea = i[1] ? i[0] : ea ^ i[0];
         eb = ~eb;
         rd(`OFS_OUT_STAT, {30'h0, eb, ea});
      end
      rd(`OFS_FLAGS, 32'h0);
      // PWM mode keeps latch and ignores force
      wr(`OFS_CTRL, 32'h75);
      wr(`OFS_FORCE, 32'h3);
      rd(`OFS_OUT_STAT, {30'h0, eb, ea});
      wr(`OFS_CTRL, 32'h10);
      cpu_model_inst.w16(`OFS_CMPA_LO, 16'h1234);
      chk("override", 32'h1, {30'h0, compare_pin_override});
      wr(`OFS_CMPB_HI, 32'h56);
      rd(`OFS_CMPA_HI, 32'h12);
      rd(`OFS_CMPA_LO, 32'h34);
      cpu_model_inst.w16(`OFS_CMPA_LO, 16'h0010);
      cpu_model_inst.w16(`OFS_CMPB_LO, 16'h0012);
      wr(`OFS_IRQ_EN, 32'h3);
      wr(`OFS_CTRL, 32'h110);
      wc(16'h0010);
      chk("match", 32'h1, {31'h0, compare_match[0]});
      chk("irq early", 32'h0, {31'h0, compare_irq[0]});
      @(posedge clock);
      chk("irq", 32'h1, {31'h0, compare_irq[0]});
      irq_ack <= 2'h1;
      @(posedge clock);
      irq_ack <= 2'h0;
      @(posedge clock);
      chk("irq ack", 32'h0, {31'h0, compare_irq[0]});
      rd(`OFS_FLAGS, 32'h2);
      wr(`OFS_FLAGS, 32'h2);
      rd(`OFS_FLAGS, 32'h0);
      ea = ~ea;
      rd(`OFS_OUT_STAT, {30'h0, eb, ea});
      // Count written equal to compare A loses that match only
      wr(`OFS_CTRL, 32'h10);
      cpu_model_inst.w16(`OFS_CNT_LO, 16'h0010);
      wr(`OFS_CTRL, 32'h110);
      wc(16'h0014);
      rd(`OFS_FLAGS, 32'h2);
      rd(`OFS_OUT_STAT, {30'h0, eb, ea});
      // Compare A as top, then count written at top
      wr(`OFS_CTRL, 32'h4);
      cpu_model_inst.w16(`OFS_CMPA_LO, 16'h0003);
      cpu_model_inst.w16(`OFS_CNT_LO, 16'h0000);
      wr(`OFS_CTRL, 32'h104);
      for (i = 0; i < 12; i++) begin
         @(posedge clock);
         chk("count top", 32'h1, {31'h0, timer_count <= 16'h3});
      end
      wr(`OFS_CTRL, 32'hF);
      cpu_model_inst.w16(`OFS_CNT_LO, 16'h0003);
      wr(`OFS_CTRL, 32'h10F);
      wc(16'h0005);
      chk("count", 32'h5, {16'h0, timer_count});
      wrap_up();
   end
endmodule : timer16_output_compare_tb
`default_nettype wire
